// File: include/ppwc_defines.svh
`ifndef PPWC_DEFINES_SVH
`define PPWC_DEFINES_SVH

`define PPWC_NUM_CH 6
`define PPWC_CNT_W 16
`define PPWC_CNT_MAX 16'hFFFF

// register byte addresses
`define PPWC_MODE_BASE 8'h00
`define PPWC_CAPT_BASE 8'h20
`define PPWC_START_OFF 8'h40
`define PPWC_STAT_OFF 8'h44
`define PPWC_MASK_OFF 8'h48
`define PPWC_LEVEL_OFF 8'h4C

// mode register fields
`define PPWC_TMOD_LO 0
`define PPWC_TMOD_HI 1
`define PPWC_MR_LO 2
`define PPWC_MR_HI 3
`define PPWC_MR_RSVD 4
`define PPWC_OVF_BIT 5
`define PPWC_TCK_LO 6
`define PPWC_TCK_HI 7
`define PPWC_OP_MEASURE 2'b10
`define PPWC_MODE_RESET 8'h00

// status and mask layout
`define PPWC_STAT_CAP_LSB 0
`define PPWC_STAT_OVF_LSB 8

// prescaler ratios
`define PPWC_DIV8 8
`define PPWC_DIV32 32

`endif

// File: include/ppwc_pkg.sv
package ppwc_pkg;

	typedef enum logic [1:0] {
		PPWC_PERIOD_FALL = 2'b00,
		PPWC_PERIOD_RISE = 2'b01,
		PPWC_WIDTH = 2'b10,
		PPWC_MEAS_RSVD = 2'b11
	} ppwc_meas_t;

	typedef enum logic [1:0] {
		PPWC_CLK_F1 = 2'b00,
		PPWC_CLK_F8 = 2'b01,
		PPWC_CLK_F32 = 2'b10,
		PPWC_CLK_FC32 = 2'b11
	} ppwc_clk_t;

	// true when the pin change qualifies as a capture edge
	function automatic logic ppwc_edge_hit(input ppwc_meas_t sel, input logic prev,
			input logic cur);
		case (sel)
			PPWC_PERIOD_FALL: return prev & ~cur;
			PPWC_PERIOD_RISE: return ~prev & cur;
			PPWC_WIDTH: return prev ^ cur;
			default: return 1'b0;
		endcase
	endfunction : ppwc_edge_hit

	function automatic logic ppwc_pick_tick(input ppwc_clk_t sel, input logic t8,
			input logic t32, input logic tsub);
		case (sel)
			PPWC_CLK_F1: return 1'b1;
			PPWC_CLK_F8: return t8;
			PPWC_CLK_F32: return t32;
			default: return tsub;
		endcase
	endfunction : ppwc_pick_tick

endpackage : ppwc_pkg

// File: src/ppwc_chan.sv
`timescale 1ns/100ps
`default_nettype none
`include "ppwc_defines.svh"

module ppwc_chan
	import ppwc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic tick,
	input wire logic pin,
	input wire ppwc_meas_t meas_sel,
	output logic [`PPWC_CNT_W-1:0] capture_value,
	output logic cap_evt,
	output logic ovf_evt
);

	logic pin_prev;
	logic [`PPWC_CNT_W-1:0] count;
	logic hit;

	assign hit = run & ppwc_edge_hit(meas_sel, pin_prev, pin);
	assign cap_evt = hit;
	assign ovf_evt = run & tick & ~hit & (count == `PPWC_CNT_MAX);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_prev <= 1'b0;
		end else begin
			pin_prev <= pin;
		end
	end

	// counter is never cleared on start, only by an edge or a wrap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
		end else if (hit) begin
			count <= '0;
		end else if (run && tick) begin
			count <= count + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_value <= '0;
		end else if (hit) begin
			capture_value <= count;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_capture_latch: assert property (hit |=> capture_value == $past(count))
		else $error("capture register missed the count");
	chk_clear_on_edge: assert property (hit |=> count == '0)
		else $error("counter not cleared on capture");
	chk_width_edges: assert property ((run && meas_sel == PPWC_WIDTH && pin != pin_prev)
		|-> cap_evt)
		else $error("width mode missed an edge");
	chk_period_single: assert property ((meas_sel == PPWC_PERIOD_FALL && pin && !pin_prev)
		|-> !cap_evt)
		else $error("falling period mode captured a rising edge");
	chk_wrap_zero: assert property (ovf_evt |=> count == '0 ##1 !ovf_evt)
		else $error("overflow did not wrap to zero");
	chk_stop_hold: assert property (!run |=> count == $past(count))
		else $error("counter moved while stopped");

endmodule : ppwc_chan

`default_nettype wire

// File: src/ppwc_top.sv
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "ppwc_defines.svh"

// Overview of operation
// - six identical channels, each able to measure period and width
// - each channel has counter and capture register; reading returns captured value
// - period mode counts falling-to-falling or rising-to-rising edges
// - once started, counter runs; a qualifying edge captures, clears, continues
// - a capture sets the request in the same cycle as the latch
// - counter overflow sets sticky overflow flag and raises the request too
// - measurement runs freely; capture register keeps the latest result
// - counter is not cleared at start; early overflow is possible
// - width mode captures and clears on both rising and falling edges
// - operating mode low bit 0 and high bit 1 selects measurement
// - overflow flag is cleared by writing zero, never set by software
// - two-bit clock select: undivided, divide by 8, by 32, sub-clock by 32
// - mode 0x42 is period with divide by 8; 0x4a is width
module ppwc_top
	import ppwc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [`PPWC_NUM_CH-1:0] measure_input_pin,
	input wire logic sub_clock_in,
	output logic irq
);

	localparam int NCH = `PPWC_NUM_CH;

	logic [NCH-1:0][7:0] mode_cfg;
	logic [NCH-1:0] overflow_flag;
	logic [NCH-1:0] count_start_bit;
	logic [NCH-1:0] cap_stat;
	logic [NCH-1:0] ovf_stat;
	logic [NCH-1:0] cap_mask;
	logic [NCH-1:0] ovf_mask;
	logic [NCH-1:0] pin_level;
	logic [NCH-1:0] run;
	logic [NCH-1:0] cap_evt;
	logic [NCH-1:0] ovf_evt;
	logic [NCH-1:0] selected_count_clock;
	logic [NCH-1:0][`PPWC_CNT_W-1:0] capture_value_reg;

	logic [4:0] div_cnt;
	logic tick_div8;
	logic tick_div32;
	logic sub_prev;
	logic [4:0] sub_cnt;
	logic tick_sub32;

	logic setup;
	logic wr_fire;
	logic [31:0] rd_word;
	logic rd_ok;
	logic [NCH-1:0] wr_mode;
	logic wr_start;
	logic wr_stat;
	logic wr_mask;

	// byte address of a per-channel register
	function automatic logic [7:0] slot_addr(input logic [7:0] base, input int idx);
		return base + 8'(idx * 4);
	endfunction : slot_addr

	// mode register as software sees it: overflow flag merged in
	function automatic logic [7:0] mode_view(input logic [7:0] cfg, input logic ovf);
		logic [7:0] v;
		v = cfg;
		v[`PPWC_OVF_BIT] = ovf;
		return v;
	endfunction : mode_view

	// prescaler: one-cycle enables for f/8 and f/32
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= '0;
			tick_div8 <= 1'b0;
			tick_div32 <= 1'b0;
		end else begin
			div_cnt <= div_cnt + 1'b1;
			tick_div8 <= (div_cnt[2:0] == 3'(`PPWC_DIV8 - 1));
			tick_div32 <= (div_cnt == 5'(`PPWC_DIV32 - 1));
		end
	end

	// sub-clock divided by 32: counts rising edges of the slow input
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sub_prev <= 1'b0;
			sub_cnt <= '0;
			tick_sub32 <= 1'b0;
		end else begin
			sub_prev <= sub_clock_in;
			tick_sub32 <= 1'b0;
			if (sub_clock_in && !sub_prev) begin
				sub_cnt <= sub_cnt + 1'b1;
				tick_sub32 <= (sub_cnt == 5'(`PPWC_DIV32 - 1));
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : gen_ch
			assign run[g] = count_start_bit[g] &
				(mode_cfg[g][`PPWC_TMOD_HI:`PPWC_TMOD_LO] == `PPWC_OP_MEASURE);
			assign selected_count_clock[g] = ppwc_pick_tick(
				ppwc_clk_t'(mode_cfg[g][`PPWC_TCK_HI:`PPWC_TCK_LO]),
				tick_div8, tick_div32, tick_sub32);
			ppwc_chan u_chan (
				.pclk(pclk),
				.presetn(presetn),
				.run(run[g]),
				.tick(selected_count_clock[g]),
				.pin(measure_input_pin[g]),
				.meas_sel(ppwc_meas_t'(mode_cfg[g][`PPWC_MR_HI:`PPWC_MR_LO])),
				.capture_value(capture_value_reg[g]),
				.cap_evt(cap_evt[g]),
				.ovf_evt(ovf_evt[g])
			);
		end
	endgenerate

	assign setup = psel & ~penable;
	assign wr_fire = psel & penable & pready & pwrite;

	// address decode shared by read and write paths
	always_comb begin
		rd_word = '0;
		rd_ok = 1'b0;
		wr_mode = '0;
		wr_start = 1'b0;
		wr_stat = 1'b0;
		wr_mask = 1'b0;
		for (int i = 0; i < NCH; i++) begin
			if (paddr == slot_addr(`PPWC_MODE_BASE, i)) begin
				rd_word = {24'h00_0000, mode_view(mode_cfg[i], overflow_flag[i])};
				rd_ok = 1'b1;
				wr_mode[i] = wr_fire;
			end
			if (paddr == slot_addr(`PPWC_CAPT_BASE, i)) begin
				rd_word = {16'h0000, capture_value_reg[i]};
				rd_ok = 1'b1;
			end
		end
		case (paddr)
			`PPWC_START_OFF: begin
				rd_word = {26'h000_0000, count_start_bit};
				rd_ok = 1'b1;
				wr_start = wr_fire;
			end
			`PPWC_STAT_OFF: begin
				rd_word = {18'h0_0000, ovf_stat, 2'b00, cap_stat};
				rd_ok = 1'b1;
				wr_stat = wr_fire;
			end
			`PPWC_MASK_OFF: begin
				rd_word = {18'h0_0000, ovf_mask, 2'b00, cap_mask};
				rd_ok = 1'b1;
				wr_mask = wr_fire;
			end
			`PPWC_LEVEL_OFF: begin
				rd_word = {26'h000_0000, pin_level};
				rd_ok = 1'b1;
			end
			default: begin
			end
		endcase
	end

	// zero-wait slave: answer registered during the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else if (setup) begin
			pready <= 1'b1;
			pslverr <= ~rd_ok;
			prdata <= (pwrite || !rd_ok) ? 32'h0000_0000 : rd_word;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end
	end

	// mode bits except the overflow flag, which has its own owner
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_cfg <= {NCH{`PPWC_MODE_RESET}};
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (wr_mode[i]) begin
					mode_cfg[i] <= pwdata[7:0] & ~(8'h01 << `PPWC_OVF_BIT);
				end
			end
		end
	end

	// overflow flag: hardware sets, a written zero clears, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overflow_flag <= '0;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (ovf_evt[i]) begin
					overflow_flag[i] <= 1'b1;
				end else if (wr_mode[i] && !pwdata[`PPWC_OVF_BIT]) begin
					overflow_flag[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_start_bit <= '0;
		end else if (wr_start) begin
			count_start_bit <= pwdata[NCH-1:0];
		end
	end

	// sticky request bits, write one to clear, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_stat <= '0;
			ovf_stat <= '0;
		end else begin
			cap_stat <= cap_evt | (cap_stat &
				~({NCH{wr_stat}} & pwdata[`PPWC_STAT_CAP_LSB +: NCH]));
			ovf_stat <= ovf_evt | (ovf_stat &
				~({NCH{wr_stat}} & pwdata[`PPWC_STAT_OVF_LSB +: NCH]));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_mask <= '0;
			ovf_mask <= '0;
		end else if (wr_mask) begin
			cap_mask <= pwdata[`PPWC_STAT_CAP_LSB +: NCH];
			ovf_mask <= pwdata[`PPWC_STAT_OVF_LSB +: NCH];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |((cap_stat & cap_mask) | (ovf_stat & ovf_mask));
		end
	end

	// input level for software to tell a high width from a low one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_level <= '0;
		end else begin
			pin_level <= measure_input_pin;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_irq_level: assert property (
		(|((cap_stat & cap_mask) | (ovf_stat & ovf_mask))) |=> irq)
		else $error("unmasked request did not raise irq");
	chk_irq_quiet: assert property (
		!(|((cap_stat & cap_mask) | (ovf_stat & ovf_mask))) |=> !irq)
		else $error("irq high with no unmasked request");
	chk_capt_request: assert property (cap_evt[0] |=> cap_stat[0])
		else $error("capture did not set its request");
	chk_ovf_sticky: assert property (ovf_evt[0] |=> overflow_flag[0] && ovf_stat[0])
		else $error("overflow did not set flag and request");
	chk_ovf_no_set: assert property (
		(!overflow_flag[0] && !ovf_evt[0]) |=> !overflow_flag[0])
		else $error("overflow flag set without overflow");
	chk_run_needs_mode: assert property (
		(mode_cfg[0][`PPWC_TMOD_HI:`PPWC_TMOD_LO] != `PPWC_OP_MEASURE) |-> !run[0])
		else $error("channel runs outside measurement mode");
	chk_apb_answer: assert property (setup |=> pready ##1 (!pready || $past(setup)))
		else $error("slave answer not one cycle");
	chk_div8_spacing: assert property (tick_div8 |=> !tick_div8 [*7] ##1 tick_div8)
		else $error("divide by 8 enable spacing wrong");

	cov_width_capture: cover property (
		cap_evt[0] && mode_cfg[0][`PPWC_MR_HI:`PPWC_MR_LO] == PPWC_WIDTH);
	cov_period_capture: cover property (
		cap_evt[1] && mode_cfg[1][`PPWC_MR_HI:`PPWC_MR_LO] == PPWC_PERIOD_FALL);
	cov_overflow: cover property (ovf_evt[0] ##1 overflow_flag[0]);
	cov_irq_rise: cover property (!irq ##1 irq);
	cov_bad_addr: cover property (pready && pslverr);

endmodule : ppwc_top

`default_nettype wire

// File: tb/ppwc_wave_gen.sv
`timescale 1ns/100ps
`default_nettype none

module ppwc_wave_gen (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [5:0] run,
	input wire logic [15:0] high_len,
	input wire logic [15:0] low_len,
	output logic [5:0] pin
);
	logic [15:0] phase_cnt;
	logic level;

	// one shared square wave; each level lasts its length in clocks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_cnt <= 16'h0001;
			level <= 1'b0;
		end else if (phase_cnt >= (level ? high_len : low_len)) begin
			phase_cnt <= 16'h0001;
			level <= ~level;
		end else begin
			phase_cnt <= phase_cnt + 16'h0001;
		end
	end

	// a stopped channel holds its last level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin <= 6'h00;
		end else begin
			pin <= (pin & ~run) | ({6{level}} & run);
		end
	end
endmodule : ppwc_wave_gen

`default_nettype wire

// File: tb/pulse_period_width_capture_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "ppwc_defines.svh"

module pulse_period_width_capture_bench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [5:0] pin, run;
	logic [15:0] high_len, low_len;
	logic [1:0] sub_div;
	int errors, checks_done, cyc, t0, k;
	logic [7:0] modes [5] = '{8'h02, 8'h06, 8'h42, 8'h82, 8'hc2};
	int halves [5] = '{10, 12, 40, 160, 640};
	int divs [5] = '{1, 1, 8, 32, 128};

	ppwc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .measure_input_pin(pin), .sub_clock_in(sub_div[1]), .irq(irq));
	ppwc_wave_gen wave (.pclk(pclk), .presetn(presetn), .run(run), .high_len(high_len),
		.low_len(low_len), .pin(pin));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// sub-clock rises every fourth clock
	always @(posedge pclk) begin
		sub_div <= sub_div + 2'h1;
		cyc <= cyc + 1;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		if (pready !== 1'b1) errors++;
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
		xfer(1'b0, a, 32'h0000_0000);
		check(q, exp);
		check({31'h0000_0000, err}, {31'h0000_0000, eerr});
	endtask : rdc

	task automatic wait_edge(input logic lvl);
		int n;
		n = 0;
		while (pin[0] === lvl && n < 4000) begin
			@(posedge pclk);
			n++;
		end
		while (pin[0] !== lvl && n < 4000) begin
			@(posedge pclk);
			n++;
		end
	endtask : wait_edge

	task automatic final_report;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report

	initial begin
		#1800000;
		errors++;
		final_report();
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		run = 6'h00;
		high_len = 16'h000a;
		low_len = 16'h000a;
		sub_div = 2'h0;
		cyc = 0;
		errors = 0;
		checks_done = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(`PPWC_MODE_BASE, 32'h0000_0000, 1'b0);
		rdc(`PPWC_CAPT_BASE, 32'h0000_0000, 1'b0);
		rdc(`PPWC_START_OFF, 32'h0000_0000, 1'b0);
		rdc(`PPWC_MASK_OFF, 32'h0000_0000, 1'b0);
		rdc(8'h50, 32'h0000_0000, 1'b1);
		wr(`PPWC_MODE_BASE + 8'h04, 32'h0000_0001);
		wr(`PPWC_MODE_BASE + 8'h08, 32'h0000_0022);
		rdc(`PPWC_MODE_BASE + 8'h08, 32'h0000_0002, 1'b0);
		run <= 6'h03;
		for (k = 0; k < 5; k++) begin
			wr(`PPWC_MODE_BASE, {24'h00_0000, modes[k]});
			if (k == 0) begin
				wr(`PPWC_START_OFF, 32'h0000_0007);
				t0 = cyc;
			end
			high_len <= 16'(halves[k]);
			low_len <= 16'(halves[k]);
			repeat (3) wait_edge(modes[k][2]);
			xfer(1'b0, `PPWC_CAPT_BASE, 32'h0000_0000);
			// a prescaled tick may or may not land in the capture window
			if (divs[k] > 1 && q === 32'(2 * halves[k] / divs[k])) q = q - 32'h0000_0001;
			check(q, 32'(2 * halves[k] / divs[k] - 1));
		end
		wr(`PPWC_MODE_BASE, 32'h0000_000a);
		high_len <= 16'h000a;
		low_len <= 16'h0006;
		repeat (2) wait_edge(1'b1);
		rdc(`PPWC_LEVEL_OFF, 32'h0000_0003, 1'b0);
		rdc(`PPWC_CAPT_BASE, 32'h0000_0005, 1'b0);
		wait_edge(1'b0);
		rdc(`PPWC_CAPT_BASE, 32'h0000_0009, 1'b0);
		rdc(`PPWC_CAPT_BASE + 8'h04, 32'h0000_0000, 1'b0);
		rdc(`PPWC_STAT_OFF, 32'h0000_0001, 1'b0);
		check({31'h0000_0000, irq}, 32'h0000_0000);
		wr(`PPWC_MASK_OFF, 32'h0000_0001);
		@(posedge pclk);
		check({31'h0000_0000, irq}, 32'h0000_0001);
		run <= 6'h00;
		repeat (20) @(posedge pclk);
		wr(`PPWC_STAT_OFF, 32'h0000_0001);
		@(posedge pclk);
		check({31'h0000_0000, irq}, 32'h0000_0000);
		rdc(`PPWC_STAT_OFF, 32'h0000_0000, 1'b0);
		while (cyc < t0 + 65600) @(posedge pclk);
		rdc(`PPWC_MODE_BASE + 8'h08, 32'h0000_0022, 1'b0);
		rdc(`PPWC_STAT_OFF, 32'h0000_0400, 1'b0);
		wr(`PPWC_MASK_OFF, 32'h0000_0400);
		@(posedge pclk);
		check({31'h0000_0000, irq}, 32'h0000_0001);
		wr(`PPWC_MODE_BASE + 8'h08, 32'h0000_0002);
		rdc(`PPWC_MODE_BASE + 8'h08, 32'h0000_0002, 1'b0);
		final_report();
	end
endmodule : pulse_period_width_capture_bench

`default_nettype wire
